// File: dv/fwrp_host.sv
/*
  host controller model: drives select, shift clock and data, captures serial_out.
  assumes the link clock stands still (high) outside frames.
*/
`timescale 1ns/1ns
module fwrp_host (
  output logic      sck,
  output logic      serial_select_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  // ----
  // frame driver
  // ----
  initial begin
    sck = 1'b1;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic frame(input logic [7:0] tx[$], input int nbits, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    serial_select_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      serial_in = tx[i/8][i%8];
      #80 sck = 1'b1;
      b[i%8] = serial_out;
      if (i % 8 == 7) begin
        rx.push_back(b);
      end
      #80;
    end
    serial_select_n = 1'b1;
    serial_in = ~serial_in;
    #160;
  endtask
endmodule // fwrp_host

// File: dv/fwrp_port_monitor.sv
/*
  pin-level checker for fwrp_port.
  assumes one core clock domain; bound into every fwrp_port instance.
*/
`timescale 1ns/1ns
module fwrp_port_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       sck,
  input wire logic       serial_select_n,
  input wire logic       serial_in,
  input wire logic       serial_out,
  input wire logic [7:0] target_select_code,
  input wire logic       frame_reflect,
  input wire logic       reflect_busy,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_idle_low; serial_select_n[*5] |-> !serial_out; endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("serial_out high while deselected");
  property p_rise_sel; $rose(serial_out) |-> !serial_select_n; endproperty
  a_rise_sel: assert property (p_rise_sel)
    else $error("serial_out rose outside a frame");
  property p_sck_hi; (!serial_select_n && sck)[*3] |-> $stable(serial_out); endproperty
  a_sck_hi: assert property (p_sck_hi)
    else $error("serial_out moved while sck high");
  property p_clear;
    $fell(rst) |-> (reflect_busy && !serial_out)[*8] ##[1:300] !reflect_busy;
  endproperty
  a_clear: assert property (p_clear)
    else $error("post-reset clear wrong");
  property p_refl_go; frame_reflect && !reflect_busy |=> reflect_busy[*8]; endproperty
  a_refl_go: assert property (p_refl_go)
    else $error("reflection did not start");
  property p_refl_len; $rose(reflect_busy) |-> ##[250:600] $fell(reflect_busy); endproperty
  a_refl_len: assert property (p_refl_len)
    else $error("reflection length wrong");
  property p_no_refl; !reflect_busy && !frame_reflect |=> !reflect_busy; endproperty
  a_no_refl: assert property (p_no_refl)
    else $error("busy without a reflection pulse");
  property p_cfg_hold;
    serial_select_n[*8] ##0 (!reflect_busy && !$past(reflect_busy) && !frame_reflect
      && $stable(cfg_addr)) |=> $stable(cfg_data);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("register changed with no transfer");
  c_refl: cover property (frame_reflect && !reflect_busy);
  c_out: cover property ($rose(serial_out));
  c_cfg: cover property ($changed(cfg_data) && !reflect_busy);
endmodule // fwrp_port_monitor

bind fwrp_port fwrp_port_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .sck(sck), .serial_select_n(serial_select_n),
  .serial_in(serial_in), .serial_out(serial_out), .target_select_code(target_select_code),
  .frame_reflect(frame_reflect), .reflect_busy(reflect_busy), .cfg_addr(cfg_addr),
  .cfg_data(cfg_data)
);

// File: dv/fwrp_port_tb_top.sv
/*
  self-checking bench for fwrp_port with a host model on the link.
  assumes the device code is 05h unless a test moves it, and the clear sweep leaves 00h.
*/
`timescale 1ns/1ns
module fwrp_port_tb_top;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] addr;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] e0;
    logic [7:0] e1;
  } fwrp_row_s;
  // code, address, two data bytes, then the two bytes expected back
  localparam fwrp_row_s ROWS [9] = '{
    '{8'h05, 8'h10, 8'hA5, 8'h3C, 8'h00, 8'h00}, '{8'h05, 8'h10, 8'h5A, 8'hC3, 8'hA5, 8'h3C},
    '{8'h06, 8'h10, 8'h11, 8'h22, 8'h00, 8'h00}, '{8'h85, 8'h10, 8'h77, 8'h88, 8'h5A, 8'hC3},
    '{8'h85, 8'h10, 8'h00, 8'h00, 8'h5A, 8'hC3}, '{8'h92, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h05, 8'hFF, 8'h9E, 8'h01, 8'h00, 8'h00}, '{8'h05, 8'h80, 8'h44, 8'h66, 8'h00, 8'h00},
    '{8'h85, 8'hFF, 8'h00, 8'h00, 8'h9E, 8'h01}};

  logic       core_clk, rst, sck, serial_select_n, serial_in, serial_out;
  logic       frame_reflect, reflect_busy;
  logic [7:0] cfg_addr, cfg_data, a0, a1, dev_code;
  logic [7:0] act [256];
  logic [7:0] rx [$];
  int         num_errors, cmp_count, cyc;

  fwrp_port DUT (
    .core_clk(core_clk), .rst(rst), .sck(sck), .serial_select_n(serial_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .target_select_code(dev_code),
    .frame_reflect(frame_reflect), .reflect_busy(reflect_busy), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data)
  );
  fwrp_host u_host (
    .sck(sck), .serial_select_n(serial_select_n), .serial_in(serial_in),
    .serial_out(serial_out)
  );

  // ----
  // clock, timeout, checks
  // ----
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      results();
    end
  end

  task results;
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chk_cfg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk) cfg_addr = a;
    repeat (2) @(negedge core_clk);
    chk8(cfg_data, exp, "cfg_data");
  endtask

  task xfer(input fwrp_row_s r, input int nb);
    while (reflect_busy !== 1'b0) @(negedge core_clk);
    u_host.frame('{r.code, r.addr, r.d0, r.d1}, nb, rx);
  endtask

  // ----
  // sequence
  // ----
  initial begin
    rst = 1'b1;
    frame_reflect = 1'b0;
    cfg_addr = 8'h00;
    dev_code = 8'h05;
    num_errors = 0;
    cmp_count = 0;
    repeat (4) @(negedge core_clk);
    chk8({6'h00, serial_out, reflect_busy}, 8'h01, "reset outputs");
    rst = 1'b0;
    foreach (act[i]) act[i] = 8'h00;
    foreach (ROWS[i]) begin
      xfer(ROWS[i], 32);
      a0 = ROWS[i].addr;
      a1 = a0 + 8'h01;
      chk8(rx[2], ROWS[i].e0, "first out byte");
      chk8(rx[3], ROWS[i].e1, "second out byte");
      if (ROWS[i].code == 8'h05) begin
        if (a0 < 8'h80) act[a0] = ROWS[i].d0;
        if (a1 < 8'h80) act[a1] = ROWS[i].d1;
      end
      chk_cfg(a0, act[a0]);
      chk_cfg(a1, act[a1]);
    end
    @(negedge core_clk) frame_reflect = 1'b1;
    @(negedge core_clk) frame_reflect = 1'b0;
    chk8({7'h00, reflect_busy}, 8'h01, "reflection busy");
    while (reflect_busy !== 1'b0) @(negedge core_clk);
    chk_cfg(8'h80, 8'h44);
    chk_cfg(8'h81, 8'h66);
    chk_cfg(8'hFF, 8'h9E);
    // cut frame into 10h, then a stray code, then read 10h back
    xfer('{8'h05, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00}, 20);
    dev_code = 8'h13;
    xfer('{8'h13, 8'h10, 8'hEE, 8'hEE, 8'h00, 8'h00}, 32);
    chk8(rx[2], 8'h00, "out-of-range code answered");
    dev_code = 8'h05;
    xfer('{8'h85, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00}, 32);
    chk8(rx[2], 8'h5A, "partial byte stored");
    chk8(rx[3], 8'hC3, "stray code stored");
    chk_cfg(8'h10, 8'h5A);
    // reset in mid-run: outputs, then the clear sweep
    @(negedge core_clk) rst = 1'b1;
    repeat (4) @(negedge core_clk);
    chk8({6'h00, serial_out, reflect_busy}, 8'h01, "mid-run reset outputs");
    rst = 1'b0;
    xfer('{8'h85, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00}, 32);
    chk8(rx[2], 8'h00, "register not cleared");
    chk8(rx[3], 8'h00, "wrapped register not cleared");
    chk_cfg(8'h00, 8'h00);
    results();
  end
endmodule // fwrp_port_tb_top

// File: hdl/fwrp_mem.sv
/*
  byte-wide register memory: one write port, one or two registered read ports.
  assumes write and read addresses come from logic on the same clock.
*/
`timescale 1ns/1ns
module fwrp_mem #(
  parameter bit TWO_READS = 1'b1
) (
  input  wire logic                      core_clk,
  input  wire logic                      we,
  input  wire logic [fwrp_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [fwrp_pkg::BYTE_W-1:0] wr_data,
  input  wire logic [fwrp_pkg::ADDR_W-1:0] rd_a_addr,
  output logic      [fwrp_pkg::BYTE_W-1:0] rd_a_data,
  input  wire logic [fwrp_pkg::ADDR_W-1:0] rd_b_addr,
  output logic      [fwrp_pkg::BYTE_W-1:0] rd_b_data
);

  logic [fwrp_pkg::BYTE_W-1:0] mem [fwrp_pkg::REG_DEPTH];

  // ----------------------------------------------------------------
  // write and read ports
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_a_data <= mem[rd_a_addr];
  end

  generate
    if (TWO_READS) begin : g_rd_b
      always_ff @(posedge core_clk) begin
        rd_b_data <= mem[rd_b_addr];
      end
    end else begin : g_no_rd_b
      assign rd_b_data = fwrp_pkg::BYTE_ZERO;
    end
  endgenerate

endmodule // fwrp_mem

// File: hdl/fwrp_port.sv
/*
  four-wire serial register port, device side, with staged and active register copies.
  assumes sck, serial_select_n and serial_in are asynchronous pins; frame_reflect,
  target_select_code and cfg_addr come from logic on core_clk, the code held static.
*/
`timescale 1ns/1ns
// Summary of operation
// - bytes travel lsb first, eight bits each
// - transfer active only while select is low
// - serial_in sampled on sck rising edge
// - write code is configured code 02h..12h
// - read code is write code plus 80h
// - wrong code ignores bytes until select rises
// - second byte is start address, auto-increments
// - write stores bytes at incrementing addresses
// - registers updated only on whole bytes
// - write returns previous contents on serial_out
// - read dummy bytes are never stored
// - read returns current contents, incrementing address
// - frame-class writes apply at frame reflection
// - immediate-class writes apply at once
module fwrp_port (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        sck,
  input  wire logic                        serial_select_n,
  input  wire logic                        serial_in,
  output logic                             serial_out,
  input  wire logic [fwrp_pkg::BYTE_W-1:0] target_select_code,
  input  wire logic                        frame_reflect,
  output logic                             reflect_busy,
  input  wire logic [fwrp_pkg::ADDR_W-1:0] cfg_addr,
  output logic      [fwrp_pkg::BYTE_W-1:0] cfg_data
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                        sck_s1;
  logic                        sck_s2;
  logic                        sck_s3;
  logic                        sel_n_s1;
  logic                        sel_n_s2;
  logic                        sdi_s1;
  logic                        sdi_s2;
  logic                        sck_rise;
  logic                        sck_fall;
  logic                        byte_done;
  logic [fwrp_pkg::BYTE_W-1:0] next_rx_byte;
  logic [fwrp_pkg::BYTE_W-1:0] rx_shift;
  logic [fwrp_pkg::BITCNT_W-1:0] bit_cnt;
  fwrp_pkg::fwrp_frame_e       frame_state;
  logic                        is_read;
  logic [fwrp_pkg::ADDR_W-1:0] reg_addr;
  logic [1:0]                  load_pipe;
  logic [fwrp_pkg::BYTE_W-1:0] tx_shift;
  logic                        spi_we;
  logic                        spi_act_we;
  logic                        clearing;
  fwrp_pkg::fwrp_eng_e         eng_state;
  logic [fwrp_pkg::ADDR_W-1:0] eng_addr;
  logic                        eng_act_we;
  logic                        stg_we;
  logic [fwrp_pkg::ADDR_W-1:0] stg_wr_addr;
  logic [fwrp_pkg::BYTE_W-1:0] stg_wr_data;
  logic                        act_we;
  logic [fwrp_pkg::ADDR_W-1:0] act_wr_addr;
  logic [fwrp_pkg::BYTE_W-1:0] act_wr_data;
  logic [fwrp_pkg::BYTE_W-1:0] stg_rd_spi;
  logic [fwrp_pkg::BYTE_W-1:0] stg_rd_eng;
  logic                        code_ok;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_s1   <= 1'b0;
      sck_s2   <= 1'b0;
      sck_s3   <= 1'b0;
      sel_n_s1 <= 1'b1;
      sel_n_s2 <= 1'b1;
      sdi_s1   <= 1'b0;
      sdi_s2   <= 1'b0;
    end else begin
      sck_s1   <= sck;
      sck_s2   <= sck_s1;
      sck_s3   <= sck_s2;
      sel_n_s1 <= serial_select_n;
      sel_n_s2 <= sel_n_s1;
      sdi_s1   <= serial_in;
      sdi_s2   <= sdi_s1;
    end
  end

  assign sck_rise     = sck_s2 && !sck_s3 && !sel_n_s2 && !clearing;
  assign sck_fall     = !sck_s2 && sck_s3 && !sel_n_s2;
  assign byte_done    = sck_rise && (bit_cnt == fwrp_pkg::BITCNT_LAST);
  assign next_rx_byte = {sdi_s2, rx_shift[fwrp_pkg::BYTE_W-1:1]};
  assign code_ok      = (target_select_code >= fwrp_pkg::CODE_MIN) &&
                        (target_select_code <= fwrp_pkg::CODE_MAX);

  // ----------------------------------------------------------------
  // bit receive
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || sel_n_s2) begin
      bit_cnt  <= fwrp_pkg::BITCNT_ZERO;
      rx_shift <= fwrp_pkg::BYTE_ZERO;
    end else if (sck_rise) begin
      bit_cnt  <= bit_cnt + fwrp_pkg::BITCNT_ONE;
      rx_shift <= next_rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // frame sequence
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || sel_n_s2) begin
      frame_state <= fwrp_pkg::FS_CODE;
      is_read     <= 1'b0;
      reg_addr    <= fwrp_pkg::ADDR_ZERO;
    end else if (byte_done) begin
      unique case (frame_state)
        fwrp_pkg::FS_CODE: begin
          if (code_ok && next_rx_byte == target_select_code) begin
            frame_state <= fwrp_pkg::FS_ADDR;
            is_read     <= 1'b0;
          end else if (code_ok && next_rx_byte == (target_select_code | fwrp_pkg::READ_FLAG)) begin
            frame_state <= fwrp_pkg::FS_ADDR;
            is_read     <= 1'b1;
          end else begin
            frame_state <= fwrp_pkg::FS_IGNORE;
          end
        end
        fwrp_pkg::FS_ADDR: begin
          frame_state <= fwrp_pkg::FS_DATA;
          reg_addr    <= next_rx_byte;
        end
        fwrp_pkg::FS_DATA: begin
          reg_addr <= reg_addr + fwrp_pkg::ADDR_ONE;
        end
        fwrp_pkg::FS_IGNORE: begin
          frame_state <= fwrp_pkg::FS_IGNORE;
        end
      endcase
    end
  end

  // whole-byte writes; read dummies never reach the memories
  assign spi_we     = byte_done && frame_state == fwrp_pkg::FS_DATA && !is_read;
  assign spi_act_we = spi_we && !fwrp_pkg::fwrp_is_frame_class(reg_addr);

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || sel_n_s2) begin
      load_pipe <= fwrp_pkg::LOAD_ZERO;
    end else begin
      load_pipe <= {load_pipe[0], byte_done && (frame_state == fwrp_pkg::FS_ADDR ||
                                                frame_state == fwrp_pkg::FS_DATA)};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || sel_n_s2) begin
      tx_shift   <= fwrp_pkg::BYTE_ZERO;
      serial_out <= 1'b0;
    end else if (load_pipe[1]) begin
      tx_shift <= stg_rd_spi;
    end else if (sck_fall) begin
      serial_out <= tx_shift[0];
      tx_shift   <= {1'b0, tx_shift[fwrp_pkg::BYTE_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // clear and frame reflection engine
  // ----------------------------------------------------------------
  assign clearing   = eng_state == fwrp_pkg::ES_CLEAR;
  assign eng_act_we = (eng_state == fwrp_pkg::ES_WRITE && !spi_act_we) || clearing;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      eng_state <= fwrp_pkg::ES_CLEAR;
      eng_addr  <= fwrp_pkg::ADDR_ZERO;
    end else begin
      unique case (eng_state)
        fwrp_pkg::ES_CLEAR: begin
          eng_addr <= eng_addr + fwrp_pkg::ADDR_ONE;
          if (eng_addr == fwrp_pkg::ADDR_LAST) begin
            eng_state <= fwrp_pkg::ES_IDLE;
          end
        end
        fwrp_pkg::ES_IDLE: begin
          if (frame_reflect) begin
            eng_state <= fwrp_pkg::ES_READ;
            eng_addr  <= fwrp_pkg::FRAME_BASE;
          end
        end
        fwrp_pkg::ES_READ: begin
          eng_state <= fwrp_pkg::ES_WRITE;
        end
        fwrp_pkg::ES_WRITE: begin
          if (eng_act_we) begin
            eng_addr  <= eng_addr + fwrp_pkg::ADDR_ONE;
            eng_state <= (eng_addr == fwrp_pkg::ADDR_LAST) ? fwrp_pkg::ES_IDLE :
                                                             fwrp_pkg::ES_READ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reflect_busy <= 1'b1;
    end else begin
      reflect_busy <= !(eng_state == fwrp_pkg::ES_IDLE && !frame_reflect);
    end
  end

  // ----------------------------------------------------------------
  // memory port muxing
  // ----------------------------------------------------------------
  assign stg_we      = clearing || spi_we;
  assign stg_wr_addr = clearing ? eng_addr : reg_addr;
  assign stg_wr_data = clearing ? fwrp_pkg::BYTE_ZERO : next_rx_byte;
  assign act_we      = spi_act_we || eng_act_we;
  assign act_wr_addr = spi_act_we ? reg_addr : eng_addr;
  assign act_wr_data = spi_act_we ? next_rx_byte :
                       clearing   ? fwrp_pkg::BYTE_ZERO : stg_rd_eng;

  fwrp_mem #(
    .TWO_READS (1'b1)
  ) u_staged (
    .core_clk  (core_clk),
    .we        (stg_we),
    .wr_addr   (stg_wr_addr),
    .wr_data   (stg_wr_data),
    .rd_a_addr (reg_addr),
    .rd_a_data (stg_rd_spi),
    .rd_b_addr (eng_addr),
    .rd_b_data (stg_rd_eng)
  );

  fwrp_mem #(
    .TWO_READS (1'b0)
  ) u_active (
    .core_clk  (core_clk),
    .we        (act_we),
    .wr_addr   (act_wr_addr),
    .wr_data   (act_wr_data),
    .rd_a_addr (cfg_addr),
    .rd_a_data (cfg_data),
    .rd_b_addr (fwrp_pkg::ADDR_ZERO),
    .rd_b_data ()
  );

endmodule // fwrp_port

// File: shared/fwrp_pkg.sv
/*
  constants, state types and the register class decode for the four-wire register port.
  assumes one core clock domain; the link pins arrive unsynchronised.
*/
package fwrp_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned REG_DEPTH = 256;
  localparam int unsigned BITCNT_W  = 3;

  // ----------------------------------------------------------------
  // codes and values
  // ----------------------------------------------------------------
  localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 3'h0;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE  = 3'h1;
  localparam logic [BITCNT_W-1:0] BITCNT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;
  localparam logic [BYTE_W-1:0]   READ_FLAG   = 8'h80;
  localparam logic [BYTE_W-1:0]   CODE_MIN    = 8'h02;
  localparam logic [BYTE_W-1:0]   CODE_MAX    = 8'h12;
  localparam logic [ADDR_W-1:0]   ADDR_ZERO   = 8'h00;
  localparam logic [ADDR_W-1:0]   ADDR_ONE    = 8'h01;
  localparam logic [ADDR_W-1:0]   ADDR_LAST   = 8'hFF;
  localparam logic [ADDR_W-1:0]   FRAME_BASE  = 8'h80;
  localparam logic [1:0]          LOAD_ZERO   = 2'h0;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FS_CODE   = 4'h1,
    FS_ADDR   = 4'h2,
    FS_DATA   = 4'h4,
    FS_IGNORE = 4'h8
  } fwrp_frame_e;

  typedef enum logic [3:0] {
    ES_CLEAR = 4'h1,
    ES_IDLE  = 4'h2,
    ES_READ  = 4'h4,
    ES_WRITE = 4'h8
  } fwrp_eng_e;

  // ----------------------------------------------------------------
  // register class decode
  // ----------------------------------------------------------------
  function automatic logic fwrp_is_frame_class(input logic [ADDR_W-1:0] addr);
    return addr >= FRAME_BASE;
  endfunction

endpackage
